// *** design/sdram_cmd_ctl.sv ***
// Controller end: issues one command per request on a divided link clock.
`timescale 1ns/1ps
`include "sdram_cmd_params.svh"
module sdram_cmd_ctl (
	sdram_link_if.ctl LINK,
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic REQ_I,
	input wire logic [3:0] CMD_I,
	input wire logic [11:0] ADDR_I,
	input wire logic [1:0] MASK_I,
	input wire logic [15:0] WDATA_I,
	input wire logic CKE_I,
	output logic BUSY_O,
	output logic [15:0] RDATA_O
);
	typedef struct packed {
		logic [2:0] div;
		logic clk;
		logic pend;
		logic [3:0] cmd;
		logic [11:0] addr;
		logic [1:0] mask;
		logic [15:0] wdata;
		logic cke;
		logic req_cke;
		logic [3:0] pins;
		logic [11:0] pin_addr;
		logic [1:0] pin_mask;
		logic [15:0] pin_data;
		logic [1:0] pin_oe;
		logic [15:0] rd_s1;
		logic [15:0] rd_s2;
	} state_t;
	state_t s_q, s_d;
	// Maps a command code to the three strobes; chip select is raised at the pins when all three are high.
	function automatic logic [3:0] encode(input logic [3:0] c);
		unique case (c)
			4'h1: return 4'h3;
			4'h2: return 4'h2;
			4'h3: return 4'h5;
			4'h4: return 4'h4;
			4'h5: return 4'h6;
			4'h6: return 4'h1;
			4'h7: return 4'h0;
			default: return 4'h7;
		endcase
	endfunction
	// Divider, request capture, and pin update on the falling half so levels stand at rise.
	always_comb
	begin
		s_d = s_q;
		s_d.rd_s1 = LINK.data_lines;
		s_d.rd_s2 = s_q.rd_s1;
		s_d.div = s_q.div + 3'h1;
		if (REQ_I && !s_q.pend)
		begin
			s_d.pend = 1'b1;
			s_d.cmd = CMD_I;
			s_d.addr = ADDR_I;
			s_d.mask = MASK_I;
			s_d.wdata = WDATA_I;
			s_d.req_cke = CKE_I;
		end
		if (s_q.div == `CLK_DIV)
		begin
			s_d.div = 3'h0;
			s_d.clk = !s_q.clk;
			if (s_q.clk)
			begin
				// Pins change after the falling link edge only.
				s_d.pins = s_q.pend ? encode(s_q.cmd) : 4'h7;
				s_d.pin_addr = s_q.addr;
				s_d.pin_mask = s_q.pend ? s_q.mask : 2'h0;
				s_d.pin_data = s_q.wdata;
				s_d.pin_oe = (s_q.pend && s_q.cmd == 4'h4) ? 2'h3 : 2'h0;
				if (s_q.pend)
				begin
					// Enable moves with the other pins, so it never changes at a rising edge.
					s_d.cke = s_q.req_cke;
					// A request arriving at this very edge is not taken, since the one sent now is still pending here.
					s_d.pend = 1'b0;
				end
			end
		end
	end
	// Register stage on the system clock.
	always_ff @(posedge SYS_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			s_q <= '{pins: 4'h7, cke: 1'b1, default: '0};
		end
		else
		begin
			s_q <= s_d;
		end
	end
	assign LINK.link_clk = s_q.clk;
	assign LINK.cke = s_q.cke;
	assign {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} = {s_q.pins[3] & 1'b0, s_q.pins[2:0]} | {s_q.pins == 4'h7 ? 1'b1 : 1'b0, 3'h0};
	assign LINK.addr = s_q.pin_addr;
	assign LINK.low_byte_mask = s_q.pin_mask[0];
	assign LINK.high_byte_mask = s_q.pin_mask[1];
	assign LINK.dq_ctl_o = s_q.pin_data;
	assign LINK.dq_ctl_oe = s_q.pin_oe;
	assign BUSY_O = s_q.pend;
	assign RDATA_O = s_q.rd_s2;
endmodule

// *** design/sdram_cmd_device.sv ***
// Device end: command decoder, bank state, burst and byte-mask logic.
`timescale 1ns/1ps
`include "sdram_cmd_params.svh"
module sdram_cmd_device (
	sdram_link_if.dev LINK,
	input wire logic RST_I,
	output logic [1:0] BANK_ACTIVE_O,
	output logic BURST_O,
	output logic WRITE_O,
	output logic [1:0] POWER_STATE_O,
	output logic [11:0] MODE_O,
	output logic [15:0] WR_DATA_O,
	output logic [1:0] WR_BYTE_EN_O,
	output logic [7:0] COL_O,
	output logic REFRESH_O
);
	typedef struct packed {
		logic cke_prev;
		logic [1:0] bank_act;
		logic burst;
		logic is_write;
		logic auto_pre;
		logic burst_bank;
		logic [3:0] left;
		logic [7:0] col;
		logic [11:0] mode;
		sdram_cmd_pkg::pstate_t pst;
		logic [1:0] mask_d1;
		logic [15:0] rd_q;
		logic [1:0] rd_oe;
		logic [15:0] wr_data;
		logic [1:0] wr_en;
		logic refresh;
	} state_t;
	state_t s_q, s_d;
	logic [15:0] mem_word;
	// Decodes the four command lines into a command code.
	function automatic sdram_cmd_pkg::cmd_t decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		sdram_cmd_pkg::cmd_t c;
		c = sdram_cmd_pkg::CMD_NOP;
		if (!cs_n)
		begin
			unique case ({ras_n, cas_n, we_n})
				3'h3: c = sdram_cmd_pkg::CMD_ROW_OPEN;
				3'h2: c = sdram_cmd_pkg::CMD_ROW_CLOSE;
				3'h5: c = sdram_cmd_pkg::CMD_READ;
				3'h4: c = sdram_cmd_pkg::CMD_WRITE;
				3'h6: c = sdram_cmd_pkg::CMD_STOP;
				3'h1: c = sdram_cmd_pkg::CMD_REFRESH;
				3'h0: c = sdram_cmd_pkg::CMD_MODE;
				default: c = sdram_cmd_pkg::CMD_NOP;
			endcase
		end
		return c;
	endfunction
	// Idle-style command: deselect or no-operation.
	function automatic logic is_idle_cmd(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		return cs_n | (ras_n & cas_n & we_n);
	endfunction
	// Stand-in for the array: data pattern derived from the column.
	assign mem_word = {s_q.col, ~s_q.col};
	// Next-state logic for decoder, banks, bursts and masks.
	always_comb
	begin
		sdram_cmd_pkg::cmd_t cmd;
		logic bank;
		logic active;
		logic [1:0] mask;
		cmd = decode(LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n);
		bank = LINK.addr[`BANK_BIT];
		mask = {LINK.high_byte_mask, LINK.low_byte_mask};
		active = s_q.cke_prev && s_q.pst == sdram_cmd_pkg::ST_RUN;
		s_d = s_q;
		s_d.cke_prev = LINK.cke;
		s_d.refresh = 1'b0;
		s_d.wr_en = 2'h0;
		s_d.mask_d1 = mask;
		if (active && s_q.burst)
		begin
			if (s_q.is_write)
			begin
				s_d.wr_data = LINK.data_lines;
				s_d.wr_en = ~mask;
			end
			s_d.col = s_q.col + 8'h01;
			s_d.left = s_q.left - 4'h1;
			if (s_q.left == 4'h1)
			begin
				s_d.burst = 1'b0;
				if (s_q.auto_pre)
				begin
					s_d.bank_act[s_q.burst_bank] = 1'b0;
				end
			end
		end
		// Read lanes: data registered, lane disabled if mask seen two edges back.
		s_d.rd_q = mem_word;
		s_d.rd_oe = (active && s_q.burst && !s_q.is_write) ? ~s_q.mask_d1 : 2'h0;
		if (active)
		begin
			unique case (cmd)
				sdram_cmd_pkg::CMD_ROW_OPEN:
					if (!s_q.bank_act[bank])
					begin
						s_d.bank_act[bank] = 1'b1;
					end
				sdram_cmd_pkg::CMD_ROW_CLOSE:
				begin
					if (LINK.addr[`AP_BIT])
					begin
						s_d.bank_act = 2'h0;
					end
					else
					begin
						s_d.bank_act[bank] = 1'b0;
					end
					if (LINK.addr[`AP_BIT] || s_q.burst_bank == bank)
					begin
						s_d.burst = 1'b0;
					end
				end
				sdram_cmd_pkg::CMD_READ, sdram_cmd_pkg::CMD_WRITE:
					if (s_q.bank_act[bank])
					begin
						s_d.burst = 1'b1;
						s_d.is_write = (cmd == sdram_cmd_pkg::CMD_WRITE);
						s_d.auto_pre = LINK.addr[`AP_BIT];
						s_d.burst_bank = bank;
						// The first beat is the start column itself.
						s_d.col = LINK.addr[`COL_W-1:0];
						s_d.left = `BURST_LEN - 4'h1;
						if (cmd == sdram_cmd_pkg::CMD_WRITE)
						begin
							s_d.wr_data = LINK.data_lines;
							s_d.wr_en = ~mask;
						end
						if (`BURST_LEN == 4'h1)
						begin
							s_d.burst = 1'b0;
						end
					end
				sdram_cmd_pkg::CMD_STOP:
					s_d.burst = 1'b0;
				sdram_cmd_pkg::CMD_REFRESH:
					if (s_q.bank_act == 2'h0)
					begin
						if (LINK.cke)
						begin
							s_d.refresh = 1'b1;
						end
						else
						begin
							s_d.pst = sdram_cmd_pkg::ST_SELF_REFRESH;
						end
					end
				sdram_cmd_pkg::CMD_MODE:
					if (s_q.bank_act == 2'h0)
					begin
						s_d.mode = LINK.addr;
					end
				default:
				begin
				end
			endcase
		end
		// Clock-enable state transitions.
		unique case (s_q.pst)
			sdram_cmd_pkg::ST_RUN:
				if (s_q.cke_prev && !LINK.cke && s_d.pst == sdram_cmd_pkg::ST_RUN)
				begin
					if (s_q.burst || s_q.bank_act != 2'h0)
					begin
						s_d.pst = sdram_cmd_pkg::ST_SUSPEND;
					end
					else if (is_idle_cmd(LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n))
					begin
						s_d.pst = sdram_cmd_pkg::ST_POWER_DOWN;
					end
				end
			sdram_cmd_pkg::ST_SUSPEND:
				if (LINK.cke)
				begin
					s_d.pst = sdram_cmd_pkg::ST_RUN;
				end
			sdram_cmd_pkg::ST_POWER_DOWN, sdram_cmd_pkg::ST_SELF_REFRESH:
				if (LINK.cke && is_idle_cmd(LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n))
				begin
					s_d.pst = sdram_cmd_pkg::ST_RUN;
				end
		endcase
	end
	// State register on the link clock.
	always_ff @(posedge LINK.link_clk or posedge RST_I)
	begin
		if (RST_I)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end
	assign LINK.dq_dev_o = s_q.rd_q;
	assign LINK.dq_dev_oe = s_q.rd_oe;
	assign BANK_ACTIVE_O = s_q.bank_act;
	assign BURST_O = s_q.burst;
	assign WRITE_O = s_q.is_write;
	assign POWER_STATE_O = s_q.pst;
	assign MODE_O = s_q.mode;
	assign WR_DATA_O = s_q.wr_data;
	assign WR_BYTE_EN_O = s_q.wr_en;
	assign COL_O = s_q.col;
	assign REFRESH_O = s_q.refresh;
endmodule

// *** design/sdram_cmd_params.svh ***
// Constants shared by both ends of the command link.
`ifndef SDRAM_CMD_PARAMS_SVH
`define SDRAM_CMD_PARAMS_SVH
`define DATA_W 16
`define ADDR_W 12
`define BANK_BIT 11
`define AP_BIT 10
`define COL_W 8
`define HI_LO 8
`define BURST_LEN 4'h4
`define RD_LAT 2'h2
`define CLK_DIV 3'h3
`endif

// *** design/sdram_cmd_pkg.sv ***
// Types for the command decoder link.
package sdram_cmd_pkg;
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_ROW_OPEN = 4'h1,
		CMD_ROW_CLOSE = 4'h2,
		CMD_READ = 4'h3,
		CMD_WRITE = 4'h4,
		CMD_STOP = 4'h5,
		CMD_REFRESH = 4'h6,
		CMD_MODE = 4'h7
	} cmd_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_SUSPEND = 2'h1,
		ST_POWER_DOWN = 2'h3,
		ST_SELF_REFRESH = 2'h2
	} pstate_t;
endpackage

// *** design/sdram_link_if.sv ***
// Pin bundle between the memory controller and the memory device.
`timescale 1ns/1ps
interface sdram_link_if;
	logic link_clk;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [11:0] addr;
	logic low_byte_mask;
	logic high_byte_mask;
	logic [15:0] dq_ctl_o;
	logic [1:0] dq_ctl_oe;
	logic [15:0] dq_dev_o;
	logic [1:0] dq_dev_oe;
	// Resolved data_lines level per byte lane.
	logic [15:0] data_lines;
	assign data_lines[7:0] = dq_ctl_oe[0] ? dq_ctl_o[7:0] : (dq_dev_oe[0] ? dq_dev_o[7:0] : 8'h00);
	assign data_lines[15:8] = dq_ctl_oe[1] ? dq_ctl_o[15:8] : (dq_dev_oe[1] ? dq_dev_o[15:8] : 8'h00);
	modport ctl (output link_clk, cke, cs_n, ras_n, cas_n, we_n, addr, low_byte_mask,
		high_byte_mask, dq_ctl_o, dq_ctl_oe, input data_lines);
	modport dev (input link_clk, cke, cs_n, ras_n, cas_n, we_n, addr, low_byte_mask,
		high_byte_mask, data_lines, output dq_dev_o, dq_dev_oe);
endinterface

// *** tb/sdram_link_properties.sv ***
// Concurrent checks on the command link between the two ends.
`timescale 1ns/1ps
module sdram_link_properties (
	input logic link_clk,
	input logic RST_I,
	input logic cke,
	input logic cs_n,
	input logic ras_n,
	input logic cas_n,
	input logic we_n,
	input logic [11:0] addr,
	input logic low_byte_mask,
	input logic high_byte_mask,
	input logic [1:0] dq_ctl_oe,
	input logic [1:0] dq_dev_oe
);
	logic cke_q;
	logic [1:0] bank_q;
	logic [3:0] rd_age_q;
	logic live;
	logic [2:0] code;
	default clocking @(posedge link_clk); endclocking
	default disable iff (RST_I);
	// A command counts only when selected with the enable high one edge earlier.
	assign live = !cs_n && cke_q;
	assign code = {ras_n, cas_n, we_n};
	// Tracks the last enable, the open banks and the age of the last read.
	always_ff @(posedge link_clk or posedge RST_I)
	begin
		if (RST_I)
		begin
			cke_q <= 1'b1;
			bank_q <= 2'h0;
			rd_age_q <= 4'hF;
		end
		else
		begin
			cke_q <= cke;
			if (live && code == 3'b011)
				bank_q[addr[11]] <= 1'b1;
			else if (live && code == 3'b010)
				bank_q <= addr[10] ? 2'h0 : (bank_q & ~(2'h1 << addr[11]));
			else if (live && code[2:1] == 2'b10 && addr[10])
				bank_q[addr[11]] <= 1'b0;
			if (live && code == 3'b101)
				rd_age_q <= 4'h0;
			else if (rd_age_q != 4'hF)
				rd_age_q <= rd_age_q + 4'h1;
		end
	end
	a_open_idle_bank: assert property (live && code == 3'b011 |-> !bank_q[addr[11]])
		else $error("row open sent to an open bank");
	a_access_open_bank: assert property (live && code[2:1] == 2'b10 |-> bank_q[addr[11]])
		else $error("column access to an idle bank");
	a_mode_when_idle: assert property (live && code == 3'b000 |-> bank_q == 2'h0)
		else $error("mode load with a bank open");
	a_refresh_when_idle: assert property (live && code == 3'b001 |-> bank_q == 2'h0)
		else $error("refresh with a bank open");
	a_sleep_entry_code: assert property ($fell(cke) && bank_q == 2'h0 && rd_age_q > 4'h6
		|-> cs_n || code == 3'b111 || code == 3'b001) else $error("bad sleep entry code");
	a_sleep_exit_code: assert property ($rose(cke) && bank_q == 2'h0 |-> cs_n || code == 3'b111)
		else $error("bad sleep exit code");
	a_low_lane_mask: assert property (dq_dev_oe[0] |-> !$past(low_byte_mask, 2))
		else $error("low lane driven while masked");
	a_high_lane_mask: assert property (dq_dev_oe[1] |-> !$past(high_byte_mask, 2))
		else $error("high lane driven while masked");
	a_lane_contention: assert property ((dq_ctl_oe & dq_dev_oe) == 2'h0)
		else $error("both ends drive one lane");
	a_read_drive_span: assert property (dq_dev_oe != 2'h0 |-> rd_age_q <= 4'h6)
		else $error("device drives outside a read");
	// Main scenarios reached.
	c_write: cover property (live && code == 3'b100);
	c_read: cover property (live && code == 3'b101);
	c_suspend: cover property ($fell(cke) && bank_q != 2'h0);
endmodule

// *** tb/testbench.sv ***
// Self-checking bench joining the controller and device ends of the link.
`timescale 1ns/1ps
module testbench;
	logic SYS_CLK_I;
	logic RST_I;
	logic req;
	logic [3:0] cmd;
	logic [11:0] addr;
	logic [1:0] mask;
	logic [15:0] wdata;
	logic cke;
	logic busy;
	logic [1:0] bank;
	logic burst;
	logic write;
	logic [1:0] pstate;
	logic [11:0] mode;
	logic [15:0] wr_data;
	logic [1:0] wr_en;
	logic refresh;
	logic [15:0] rdata;
	logic [7:0] col;
	int num_errors;
	int compares;
	sdram_link_if link ();
	sdram_cmd_ctl sdram_cmd_ctl_inst (.LINK(link.ctl), .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
		.REQ_I(req), .CMD_I(cmd), .ADDR_I(addr), .MASK_I(mask), .WDATA_I(wdata),
		.CKE_I(cke), .BUSY_O(busy), .RDATA_O(rdata));
	sdram_cmd_device sdram_cmd_device_inst (.LINK(link.dev), .RST_I(RST_I),
		.BANK_ACTIVE_O(bank), .BURST_O(burst), .WRITE_O(write), .POWER_STATE_O(pstate),
		.MODE_O(mode), .WR_DATA_O(wr_data), .WR_BYTE_EN_O(wr_en), .COL_O(col),
		.REFRESH_O(refresh));
	sdram_link_properties sdram_link_properties_inst (.link_clk(link.link_clk),
		.RST_I(RST_I), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr),
		.low_byte_mask(link.low_byte_mask), .high_byte_mask(link.high_byte_mask),
		.dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe));
	// System clock at 100 MHz.
	initial
	begin
		SYS_CLK_I = 1'b0;
		forever #5 SYS_CLK_I = ~SYS_CLK_I;
	end
	// Compares one value and counts the outcome.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Issues one command and returns just after the link edge that samples it.
	task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic [1:0] m,
		input logic [15:0] d, input logic k);
		int n;
		@(posedge SYS_CLK_I);
		req <= 1'b1;
		cmd <= c;
		addr <= a;
		mask <= m;
		wdata <= d;
		cke <= k;
		@(posedge SYS_CLK_I);
		req <= 1'b0;
		n = 0;
		do
		begin
			@(negedge SYS_CLK_I);
			n++;
		end
		while (busy !== 1'b0 && n < 64);
		// A request that never reaches the pins counts as a mismatch.
		if (busy !== 1'b0)
		begin
			num_errors++;
		end
		@(posedge link.link_clk);
		#1;
	endtask
	// Waits a number of link edges.
	task automatic edges(input int n);
		repeat (n) @(posedge link.link_clk);
		#1;
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge SYS_CLK_I);
		num_errors++;
		complete_run;
	end
	// Main sequence of tests.
	initial
	begin
		num_errors = 0;
		compares = 0;
		req = 1'b0;
		cmd = 4'h0;
		addr = 12'h000;
		mask = 2'h0;
		wdata = 16'h0000;
		cke = 1'b1;
		RST_I = 1'b1;
		repeat (6) @(posedge SYS_CLK_I);
		RST_I <= 1'b0;
		@(negedge SYS_CLK_I);
		chk(16'(bank), 16'h0000);
		issue(4'h7, 12'h233, 2'h0, 16'h0000, 1'b1);
		chk(16'(mode), 16'h0233);
		issue(4'h1, 12'h800, 2'h0, 16'h0000, 1'b1);
		chk(16'(bank), 16'h0002);
		issue(4'h1, 12'h000, 2'h0, 16'h0000, 1'b1);
		chk(16'(bank), 16'h0003);
		$display("test open done");
		issue(4'h4, 12'h805, 2'h2, 16'hA55A, 1'b1);
		chk(16'({wr_en, wr_data[7:0]}), 16'h015A);
		chk(16'({write, burst}), 16'h0003);
		edges(4);
		chk(16'(burst), 16'h0000);
		issue(4'h3, 12'h010, 2'h1, 16'h0000, 1'b1);
		chk(16'({write, burst}), 16'h0001);
		chk(16'(col), 16'h0010);
		issue(4'h5, 12'h000, 2'h0, 16'h0000, 1'b1);
		chk(16'(burst), 16'h0000);
		// First read beat: column pattern on the high lane, low lane masked two edges back.
		repeat (3) @(negedge SYS_CLK_I);
		chk(rdata, 16'h1000);
		$display("test access done");
		issue(4'h2, 12'h800, 2'h0, 16'h0000, 1'b1);
		chk(16'(bank), 16'h0001);
		issue(4'h1, 12'h800, 2'h0, 16'h0000, 1'b1);
		issue(4'h2, 12'h400, 2'h0, 16'h0000, 1'b1);
		chk(16'(bank), 16'h0000);
		issue(4'h6, 12'h000, 2'h0, 16'h0000, 1'b1);
		chk(16'(refresh), 16'h0001);
		$display("test close done");
		issue(4'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
		chk(16'(pstate), 16'h0003);
		issue(4'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
		chk(16'(pstate), 16'h0000);
		issue(4'h6, 12'h000, 2'h0, 16'h0000, 1'b0);
		chk(16'(pstate), 16'h0002);
		issue(4'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
		chk(16'(pstate), 16'h0000);
		issue(4'h1, 12'h000, 2'h0, 16'h0000, 1'b1);
		issue(4'h4, 12'h000, 2'h0, 16'h1234, 1'b1);
		issue(4'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
		chk(16'({pstate, burst}), 16'h0003);
		issue(4'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
		chk(16'(pstate), 16'h0000);
		$display("test power done");
		edges(4);
		issue(4'h3, 12'h407, 2'h0, 16'h0000, 1'b1);
		edges(8);
		chk(16'({bank, burst}), 16'h0000);
		$display("test autoclose done");
		complete_run;
	end
endmodule
